// File: inc/acb_pkg.sv
// Constants, types and field layout of the converter control block
package acb_pkg;

   localparam int CLK_NS        = 25;
   // Internal conversion clock period; 13 cycles give about 3.6 us
   localparam int INT_CLK_NS    = 275;
   localparam int INT_DIV       = (INT_CLK_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] INT_DIV_LAST = 4'(INT_DIV - 1);
   localparam logic [2:0] ACQ_EDGES    = 3'h4;
   localparam int CONV_CYCLES   = 13;
   localparam int RESULT_W      = 12;
   localparam int CHANS         = 6;
   localparam int BUS_W         = 10;

   localparam logic [7:0] CTRL_RST     = 8'hC8;
   localparam logic       CLK_EXT_RST  = 1'b1;
   localparam logic [1:0] PWR_FULL     = 2'h0;
   localparam logic [1:0] PWR_STANDBY  = 2'h1;
   localparam logic [1:0] PWR_INT_CLK  = 2'h2;
   localparam logic [1:0] PWR_EXT_CLK  = 2'h3;
   localparam logic [2:0] ADDR_LAST    = 3'h5;

   typedef struct packed {
      logic       power_sel_hi;
      logic       power_sel_lo;
      logic       acquisition_select;
      logic       input_pairing_select;
      logic       range_select;
      logic [2:0] chan_addr;
   } acb_ctrl_s;

   typedef struct packed {
      logic [CHANS-1:0] pos;
      logic [CHANS-1:0] neg;
      logic             common_return_pin;
      logic             unsupported;
   } acb_sel_s;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_ACQ_INT = 2'b01,
      ST_ACQ_EXT = 2'b10,
      ST_CONV    = 2'b11
   } acb_state_e;

endpackage

// File: rtl/acb_mux.sv
// Analog input multiplexer decode from the control byte
`timescale 1ns/1ps
`default_nettype none
module acb_mux
   import acb_pkg::*;
#(
   parameter int CHAN_COUNT = CHANS
) (
   input  wire logic      pairing,
   input  wire logic [2:0] addr,
   output acb_sel_s       sel
);

   always_comb begin
      sel = '0;
      if (addr > ADDR_LAST || 32'(addr) >= CHAN_COUNT) begin
         sel.unsupported = 1'b1;
      end else if (pairing) begin
         sel.pos[addr] = 1'b1;
         sel.common_return_pin       = 1'b1;
      end else begin
         sel.pos[addr]        = 1'b1;
         sel.neg[addr ^ 3'h1] = 1'b1;
      end
   end

endmodule // acb_mux
`default_nettype wire

// File: rtl/acb_sar.sv
// Successive-approximation register, one decision per conversion clock
`timescale 1ns/1ps
`default_nettype none
module acb_sar
   import acb_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                start,
   input  wire logic                tick,
   input  wire logic                comp_in,
   output logic [RESULT_W-1:0]      dac_code,
   output logic                     done
);

   logic [RESULT_W-1:0] code_reg, code_next;
   logic [RESULT_W-1:0] trial_reg, trial_next;
   logic                busy_reg, busy_next;
   logic                done_next;

   always_comb begin
      code_next  = code_reg;
      trial_next = trial_reg;
      busy_next  = busy_reg;
      done_next  = 1'b0;
      if (start) begin
         // First tick is spent on the hold switch-over
         code_next  = '0;
         trial_next = '0;
         busy_next  = 1'b1;
      end else if (busy_reg && tick) begin
         if (trial_reg == '0) begin
            trial_next = {1'b1, {(RESULT_W-1){1'b0}}};
            code_next  = {1'b1, {(RESULT_W-1){1'b0}}};
         end else begin
            if (!comp_in)
               code_next = code_reg & ~trial_reg;
            trial_next = trial_reg >> 1;
            code_next  = code_next | (trial_reg >> 1);
            if (trial_reg[0]) begin
               busy_next = 1'b0;
               done_next = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         code_reg  <= '0;
         trial_reg <= '0;
         busy_reg  <= 1'b0;
         done      <= 1'b0;
      end else begin
         code_reg  <= code_next;
         trial_reg <= trial_next;
         busy_reg  <= busy_next;
         done      <= done_next;
      end
   end

   assign dac_code = code_reg;

endmodule // acb_sar
`default_nettype wire

// File: rtl/acb_top.sv
// Control byte decode, acquisition and conversion sequencing, parallel bus
`timescale 1ns/1ps
`default_nettype none
module acb_top
   import acb_pkg::*;
#(
   parameter int CHAN_COUNT = CHANS
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                cs_n,
   input  wire logic                wr_n,
   input  wire logic                rd_n,
   input  wire logic                conv_clk_pin,
   input  wire logic [BUS_W-1:0]    bus_in,
   output logic      [BUS_W-1:0]    bus_out,
   output logic      [BUS_W-1:0]    bus_oe_n,
   output logic                     result_bit_11,
   output logic                     result_bit_10,
   output logic                     result_hi_oe_n,
   output logic                     conv_done_n,
   output logic                     conv_done_oe_n,
   input  wire logic                comp_in,
   output logic [RESULT_W-1:0]      dac_code,
   output logic [CHANS-1:0]         pos_sel,
   output logic [CHANS-1:0]         neg_sel,
   output logic                     common_return_pin_sel,
   output logic                     unsupported_addr,
   output logic                     hold_track,
   output logic                     hold_to_neg,
   output logic                     full_power_down,
   output logic                     standby_power_down,
   output logic                     clk_src_ext
);

   acb_ctrl_s           ctrl_reg, ctrl_next;
   acb_ctrl_s           wr_byte;
   acb_state_e          state_reg, state_next;
   acb_sel_s            sel;
   logic                clk_ext_reg, clk_ext_next;
   logic [3:0]          div_reg, div_next;
   logic [2:0]          edge_reg, edge_next;
   logic                wr_prev_reg, rd_prev_reg, pin_prev_reg;
   logic                track_reg, track_next;
   logic                neg_reg, neg_next;
   logic                int_n_reg, int_n_next;
   logic [RESULT_W-1:0] result_reg, result_next;
   logic                drive_reg, drive_next;
   logic                full_pd_reg, full_pd_next;
   logic                stby_pd_reg, stby_pd_next;
   logic                cdone_oe_n_reg;
   logic [CHANS-1:0]    pos_reg, neg_sel_reg;
   logic                com_reg, unsup_reg;
   logic                wr_rise, rd_fall, div_tick, tick;
   logic                conv_start;
   logic                sar_done;
   logic [RESULT_W-1:0] sar_dac;
   logic [RESULT_W-1:0] sar_bin;

   assign wr_byte = acb_ctrl_s'(bus_in[7:0]);

   // Strobes and the clock pin count only while chip select is low
   assign wr_rise  = !cs_n && !wr_prev_reg && wr_n;
   assign rd_fall  = !cs_n && rd_prev_reg && !rd_n;
   assign div_tick = (div_reg == INT_DIV_LAST);
   // Conversion clock falling edges from the chosen source
   assign tick     = clk_ext_reg ? (!cs_n && pin_prev_reg && !conv_clk_pin)
                                 : div_tick;
   assign sar_bin  = sar_dac;

   acb_mux #(
      .CHAN_COUNT (CHAN_COUNT)
   ) u_mux (
      .pairing (ctrl_reg.input_pairing_select),
      .addr    (ctrl_reg.chan_addr),
      .sel     (sel)
   );

   acb_sar u_sar (
      .clk      (clk),
      .rst      (rst),
      .start    (conv_start),
      .tick     (tick),
      .comp_in  (comp_in),
      .dac_code (sar_dac),
      .done     (sar_done)
   );

   always_comb begin
      ctrl_next    = ctrl_reg;
      state_next   = state_reg;
      clk_ext_next = clk_ext_reg;
      div_next     = div_tick ? 4'h0 : div_reg + 4'h1;
      edge_next    = edge_reg;
      track_next   = track_reg;
      neg_next     = neg_reg;
      int_n_next   = int_n_reg;
      result_next  = result_reg;
      conv_start   = 1'b0;

      case (state_reg)
         ST_ACQ_INT: begin
            if (tick) begin
               edge_next = edge_reg + 3'h1;
               if (edge_next == ACQ_EDGES) begin
                  // Hold on the fourth falling edge after the write
                  track_next = 1'b0;
                  neg_next   = 1'b1;
                  conv_start = 1'b1;
                  state_next = ST_CONV;
               end
            end
         end
         ST_CONV: begin
            if (sar_done) begin
               // Offset binary from the SAR; flip the sign bit for bipolar
               result_next = ctrl_reg.range_select ? sar_bin
                           : {~sar_bin[RESULT_W-1], sar_bin[RESULT_W-2:0]};
               neg_next    = 1'b0;
               state_next  = ST_IDLE;
            end
         end
         ST_ACQ_EXT, ST_IDLE: begin
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase

      if (rd_fall)
         int_n_next = 1'b1;
      if (state_reg == ST_CONV && sar_done)
         int_n_next = 1'b0;

      // A new write aborts whatever runs and takes priority
      if (wr_rise) begin
         ctrl_next  = wr_byte;
         int_n_next = 1'b1;
         edge_next  = 3'h0;
         if (wr_byte.power_sel_hi)
            clk_ext_next = wr_byte.power_sel_lo;
         if (state_reg == ST_ACQ_EXT && !wr_byte.acquisition_select) begin
            // Second write ends acquisition; power bits may change here
            track_next = 1'b0;
            neg_next   = 1'b1;
            conv_start = 1'b1;
            state_next = ST_CONV;
         end else if (!wr_byte.power_sel_hi) begin
            // Power-down: clock source left as it was
            track_next = 1'b0;
            neg_next   = 1'b0;
            state_next = ST_IDLE;
         end else begin
            track_next = 1'b1;
            neg_next   = 1'b0;
            state_next = wr_byte.acquisition_select ? ST_ACQ_EXT
                                                     : ST_ACQ_INT;
         end
      end

      // Power-down takes effect once no conversion is pending
      full_pd_next = (state_next == ST_IDLE) &&
                     ({ctrl_next.power_sel_hi, ctrl_next.power_sel_lo} == PWR_FULL);
      stby_pd_next = (state_next == ST_IDLE) &&
                     ({ctrl_next.power_sel_hi, ctrl_next.power_sel_lo} == PWR_STANDBY);
      drive_next   = !cs_n && !rd_n;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg       <= acb_ctrl_s'(CTRL_RST);
         state_reg      <= ST_IDLE;
         clk_ext_reg    <= CLK_EXT_RST;
         div_reg        <= 4'h0;
         edge_reg       <= 3'h0;
         wr_prev_reg    <= 1'b1;
         rd_prev_reg    <= 1'b1;
         pin_prev_reg   <= 1'b0;
         track_reg      <= 1'b0;
         neg_reg        <= 1'b0;
         int_n_reg      <= 1'b1;
         result_reg     <= '0;
         drive_reg      <= 1'b0;
         full_pd_reg    <= 1'b0;
         stby_pd_reg    <= 1'b0;
         cdone_oe_n_reg <= 1'b1;
         pos_reg        <= '0;
         neg_sel_reg    <= '0;
         com_reg        <= 1'b0;
         unsup_reg      <= 1'b0;
      end else begin
         ctrl_reg       <= ctrl_next;
         state_reg      <= state_next;
         clk_ext_reg    <= clk_ext_next;
         div_reg        <= div_next;
         edge_reg       <= edge_next;
         wr_prev_reg    <= wr_n;
         rd_prev_reg    <= rd_n;
         pin_prev_reg   <= conv_clk_pin;
         track_reg      <= track_next;
         neg_reg        <= neg_next;
         int_n_reg      <= int_n_next;
         result_reg     <= result_next;
         drive_reg      <= drive_next;
         full_pd_reg    <= full_pd_next;
         stby_pd_reg    <= stby_pd_next;
         cdone_oe_n_reg <= cs_n;
         pos_reg        <= sel.pos;
         neg_sel_reg    <= sel.neg;
         com_reg        <= sel.common_return_pin;
         unsup_reg      <= sel.unsupported;
      end
   end

   // Bus pins float one cycle after chip select or read goes high
   assign bus_out               = result_reg[BUS_W-1:0];
   assign bus_oe_n              = {BUS_W{~drive_reg}};
   assign result_bit_11         = result_reg[11];
   assign result_bit_10         = result_reg[10];
   assign result_hi_oe_n        = ~drive_reg;
   assign conv_done_n           = int_n_reg;
   assign conv_done_oe_n        = cdone_oe_n_reg;
   assign dac_code              = sar_dac;
   assign pos_sel               = pos_reg;
   assign neg_sel               = neg_sel_reg;
   assign common_return_pin_sel = com_reg;
   assign unsupported_addr      = unsup_reg;
   assign hold_track            = track_reg;
   assign hold_to_neg           = neg_reg;
   assign full_power_down       = full_pd_reg;
   assign standby_power_down    = stby_pd_reg;
   assign clk_src_ext           = clk_ext_reg;

endmodule // acb_top
`default_nettype wire

// File: bench/acb_top_checker.sv
// Concurrent checks on the control block ports
`timescale 1ns/1ps
`default_nettype none
module acb_top_checker
   import acb_pkg::*;
#(
   parameter int CHAN_COUNT = CHANS
) (
   input wire logic             clk,
   input wire logic             rst,
   input wire logic             cs_n,
   input wire logic             wr_n,
   input wire logic             rd_n,
   input wire logic [BUS_W-1:0] bus_in,
   input wire logic [BUS_W-1:0] bus_oe_n,
   input wire logic             result_hi_oe_n,
   input wire logic             conv_done_n,
   input wire logic             conv_done_oe_n,
   input wire logic [CHANS-1:0] pos_sel,
   input wire logic [CHANS-1:0] neg_sel,
   input wire logic             common_return_pin_sel,
   input wire logic             unsupported_addr,
   input wire logic             hold_track,
   input wire logic             hold_to_neg,
   input wire logic             clk_src_ext
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_done_oe_lag: assert property (conv_done_oe_n == $past(cs_n))
      else $error("done enable not following chip select");
   chk_bus_drive: assert property (!cs_n && !rd_n |=> bus_oe_n == '0 && !result_hi_oe_n)
      else $error("result not driven during read");
   chk_bus_float: assert property (cs_n || rd_n |=> &bus_oe_n && result_hi_oe_n)
      else $error("result driven outside read");
   chk_clk_mode: assert property ($rose(wr_n) && !cs_n && bus_in[7]
      |=> clk_src_ext == $past(bus_in[6])) else $error("clock source not taken");
   chk_clk_keep: assert property ($rose(wr_n) && !cs_n && !bus_in[7]
      |=> $stable(clk_src_ext)) else $error("clock source changed by power-down");
   chk_single_sel: assert property ($rose(wr_n) && !cs_n && bus_in[4]
      && int'(bus_in[2:0]) < CHAN_COUNT |=> ##1 pos_sel == (CHANS)'(1) << $past(bus_in[2:0], 2)
      && neg_sel == '0 && common_return_pin_sel) else $error("single-ended select wrong");
   chk_pair_sel: assert property ($rose(wr_n) && !cs_n && !bus_in[4]
      && int'(bus_in[2:0]) < CHAN_COUNT |=> ##1 pos_sel == (CHANS)'(1) << $past(bus_in[2:0], 2)
      && neg_sel == (CHANS)'(1) << ($past(bus_in[2:0], 2) ^ 3'h1)) else $error("pair select wrong");
   chk_unsup_addr: assert property ($rose(wr_n) && !cs_n && int'(bus_in[2:0]) >= CHAN_COUNT
      |=> ##1 unsupported_addr && pos_sel == '0 && neg_sel == '0) else $error("bad code connects");
   chk_write_track: assert property ($rose(wr_n) && !cs_n && bus_in[7] && !hold_track
      |=> hold_track && conv_done_n) else $error("write did not start tracking");
   chk_hold_swap: assert property ($rose(hold_to_neg) |-> $fell(hold_track))
      else $error("hold capacitor swapped while tracking");
   chk_done_end: assert property ($fell(conv_done_n) |-> !hold_to_neg && $past(hold_to_neg))
      else $error("done without conversion");
   chk_done_clear: assert property (!cs_n && !rd_n && $past(rd_n) && !conv_done_n
      |=> conv_done_n) else $error("read did not clear done");
endmodule // acb_top_checker
bind acb_top acb_top_checker #(.CHAN_COUNT(CHAN_COUNT)) u_chk (.clk, .rst, .cs_n, .wr_n, .rd_n,
   .bus_in, .bus_oe_n, .result_hi_oe_n, .conv_done_n, .conv_done_oe_n, .pos_sel, .neg_sel,
   .common_return_pin_sel, .unsupported_addr, .hold_track, .hold_to_neg, .clk_src_ext);
`default_nettype wire

// File: bench/acb_host.sv
// Host processor model on the parallel bus
`timescale 1ns/1ps
`default_nettype none
module acb_host
   import acb_pkg::*;
(
   input  wire logic             clk,
   output logic                  cs_n,
   output logic                  wr_n,
   output logic                  rd_n,
   output logic [BUS_W-1:0]      bus_in
);
   logic [BUS_W-1:0] data_q;
   logic             drive;
   // Released bus shows the inverse, so a stale byte is never mistaken for data
   assign bus_in = drive ? data_q : ~data_q;
   initial begin
      cs_n = 1'b1;
      wr_n = 1'b1;
      rd_n = 1'b1;
      drive = 1'b0;
      data_q = '0;
   end
   // Byte held with chip select through the edge that sees the strobe high
   task automatic write_byte(input logic [7:0] b);
      @(negedge clk);
      // Upper bus lines carry junk on a write; the byte must come from the low eight only
      data_q = {2'b11, b};
      drive = 1'b1;
      cs_n = 1'b0;
      wr_n = 1'b0;
      @(negedge clk);
      wr_n = 1'b1;
      @(negedge clk);
      drive = 1'b0;
      cs_n = 1'b1;
   endtask
   task automatic strobe(input logic c, input logic r);
      @(negedge clk);
      cs_n = c;
      rd_n = r;
   endtask
endmodule // acb_host
`default_nettype wire

// File: bench/adc_control_byte_channel_select_test.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_control_byte_channel_select_test;
   import acb_pkg::*;
   typedef struct packed {
      logic [7:0]  b;
      logic [15:0] e;
   } acb_row_s;
   acb_row_s               rows [16];
   logic                   clk = 1'b0;
   logic                   rst = 1'b1;
   logic                   conv_clk_pin = 1'b0;
   logic                   ext_run = 1'b0;
   logic [RESULT_W-1:0]    vin = '0;
   logic [2:0]             a;
   logic                   ok;
   int                     bad_count = 0;
   int                     checks = 0;
   logic                   cs_n, wr_n, rd_n, comp_in, result_bit_11, result_bit_10;
   logic                   result_hi_oe_n, conv_done_n, conv_done_oe_n, common_return_pin_sel;
   logic                   unsupported_addr, hold_track, hold_to_neg, clk_src_ext;
   logic                   full_power_down, standby_power_down;
   logic [BUS_W-1:0]       bus_in, bus_out, bus_oe_n;
   logic [RESULT_W-1:0]    dac_code;
   logic [CHANS-1:0]       pos_sel, neg_sel;
   logic [15:0]            sel_seen;
   always #12.5 clk = ~clk;
   always #125 if (ext_run) conv_clk_pin = ~conv_clk_pin;
   // Ideal comparator: keeps a trial bit while the input is at or above the trial code
   assign comp_in = (dac_code <= vin);
   assign sel_seen = {1'b0, pos_sel, neg_sel, common_return_pin_sel, unsupported_addr, hold_track};
   acb_host u_host (.clk(clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .bus_in(bus_in));
   acb_top u_dut (.clk(clk), .rst(rst), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
      .conv_clk_pin(conv_clk_pin), .bus_in(bus_in), .bus_out(bus_out), .bus_oe_n(bus_oe_n),
      .result_bit_11(result_bit_11), .result_bit_10(result_bit_10),
      .result_hi_oe_n(result_hi_oe_n), .conv_done_n(conv_done_n),
      .conv_done_oe_n(conv_done_oe_n), .comp_in(comp_in), .dac_code(dac_code),
      .pos_sel(pos_sel), .neg_sel(neg_sel), .common_return_pin_sel(common_return_pin_sel),
      .unsupported_addr(unsupported_addr), .hold_track(hold_track), .hold_to_neg(hold_to_neg),
      .full_power_down(full_power_down), .standby_power_down(standby_power_down),
      .clk_src_ext(clk_src_ext));
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Bounded wait; a hang shows up as a done mismatch
   task automatic wait_done();
      for (int k = 0; k < 3000 && conv_done_n !== 1'b0; k++) begin
         @(negedge clk);
      end
      check("done", 16'h0000, {15'h0000, conv_done_n});
   endtask
   task automatic read_result(input logic [RESULT_W-1:0] exp);
      u_host.strobe(1'b0, 1'b0);
      @(negedge clk);
      check("drive", 16'h0000, {4'h0, bus_oe_n, result_hi_oe_n, conv_done_oe_n});
      check("result", {4'h0, exp}, {4'h0, result_bit_11, result_bit_10, bus_out});
      u_host.strobe(1'b1, 1'b1);
      @(negedge clk);
      check("float", 16'h0fff, {4'h0, bus_oe_n, result_hi_oe_n, conv_done_oe_n});
      check("done clear", 16'h0001, {15'h0000, conv_done_n});
   endtask
   task automatic settle_power(input logic [2:0] exp);
      repeat (4) @(negedge clk);
      check("power", {13'h0000, exp}, {13'h0000, full_power_down, standby_power_down, clk_src_ext});
   endtask
   initial begin
      #(25 * 20000);
      bad_count++;
      end_of_test();
   end
   initial begin
      for (int i = 0; i < 16; i++) begin
         a = 3'(i);
         ok = (a <= ADDR_LAST);
         rows[i].b = {3'b100, i >= 8, 1'b1, a};
         rows[i].e = {1'b0, ok ? 6'h01 << a : 6'h00,
            (ok && i < 8) ? 6'h01 << (a ^ 3'h1) : 6'h00, ok && i >= 8, !ok, 1'b1};
      end
      repeat (2) @(negedge clk);
      check("reset", 16'hfffc, {bus_oe_n, result_hi_oe_n, conv_done_oe_n, conv_done_n,
         clk_src_ext, hold_track, hold_to_neg});
      @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check("reset select", 16'h0042, {4'h0, pos_sel, neg_sel});
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         vin = 12'(i) * 12'h0fb + 12'h03c;
         u_host.write_byte(rows[i].b);
         @(negedge clk);
         check("select", rows[i].e, sel_seen);
         wait_done();
         read_result(vin);
      end
      $display("test channel table done");
      vin = 12'h0123;
      u_host.write_byte(8'h80);
      wait_done();
      read_result(12'h0923);
      $display("test bipolar done");
      u_host.write_byte(8'ha8);
      repeat (200) @(negedge clk);
      check("ext acq", 16'h0005, {13'h0000, hold_track, hold_to_neg, conv_done_n});
      u_host.write_byte(8'h88);
      wait_done();
      read_result(vin);
      $display("test external acquisition done");
      settle_power(3'h0);
      u_host.write_byte(8'h08);
      settle_power(3'h4);
      u_host.write_byte(8'h48);
      settle_power(3'h2);
      // Ticks from the clock pin only count while chip select is low
      ext_run = 1'b1;
      u_host.write_byte(8'hc8);
      u_host.strobe(1'b0, 1'b1);
      settle_power(3'h1);
      wait_done();
      read_result(vin);
      $display("test power and clock modes done");
      end_of_test();
   end
endmodule // adc_control_byte_channel_select_test
`default_nettype wire
